// ===== inc/mailbox_pkg.sv
// mailbox_pkg: doorbell codes, mailbox offsets, reset values and timing
// assumes: shared by both ends, the checker and the bench, one 100 MHz clock
package mailbox_pkg;
  // ************************************************************
  // doorbell codes
  // ************************************************************
  localparam logic [7:0] CODE_CTRL_NEW = 8'h31;
  localparam logic [7:0] CODE_CTRL_ACK = 8'h32;
  localparam logic [7:0] CODE_STAT_REQ = 8'h33;
  localparam logic [7:0] CODE_STAT_RDY = 8'h34;
  localparam logic [7:0] CODE_STAT_ACK = 8'h35;
  // ************************************************************
  // register addresses on the device port
  // ************************************************************
  localparam logic [7:0] ADDR_H2D_DOORBELL = 8'h50;
  localparam logic [7:0] ADDR_D2H_DOORBELL = 8'h58;
  localparam logic [7:0] ADDR_BUSY = 8'h5c;
  localparam logic [7:0] MBX_WORDS = 8'h09;
  localparam logic [7:0] OFS_PROTO_IF = 8'h00;
  localparam logic [7:0] OFS_LOW_DELAY = 8'h01;
  localparam logic [7:0] OFS_WIDEBAND = 8'h03;
  localparam logic [7:0] OFS_MODE = 8'h04;
  // ************************************************************
  // reset values of the control block
  // ************************************************************
  localparam logic [7:0] RST_PROTO_IF = 8'hc1;
  localparam logic [7:0] RST_LOW_DELAY = 8'h1b;
  localparam logic [7:0] RST_OTHER = 8'h00;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PROTO_SEL_BIT = 7;
  localparam int IF_SEL_LSB = 5;
  localparam int FRAME_LEN_BIT = 4;
  localparam int UFMT_LSB = 3;
  localparam int EXC_ZERO_BIT = 2;
  localparam int POSTFILT_BIT = 0;
  localparam int WB_TEST_BIT = 7;
  localparam int ENC_MODE_LSB = 4;
  localparam int BUSY_H2D_BIT = 0;
  localparam int BUSY_D2H_BIT = 1;
  // ************************************************************
  // frame timing
  // ************************************************************
  localparam int FRAME_MS = 10;
  localparam int CLK_KHZ = 100_000;
  localparam int FRAME_CYCLES = FRAME_MS * CLK_KHZ;
  localparam int PIPE_STAGES = 3;
endpackage

// ===== inc/mailbox_if.sv
// mailbox_if: host port of the codec control path
// assumes: host drives strobes, device answers read data one cycle later
interface mailbox_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  modport host (output addr, output wdata, output wr, output rd,
    input rdata, input irq);
  modport device (input addr, input wdata, input wr, input rd,
    output rdata, output irq);
endinterface

// ===== rtl/codec_ctrl_device.sv
// codec_ctrl_device: mailbox, doorbells and settings pipeline of the codec
// assumes: host loads mailbox before ringing; frame_tick_i in offline use
//
// The plain strobed port is this design's own decision.
module codec_ctrl_device
  import mailbox_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  mailbox_if.device bus,
  input wire logic offline_i,
  input wire logic frame_tick_i,
  output logic inband_o,
  output logic [1:0] if_route_o,
  output logic frame_len_o,
  output logic [1:0] ufmt_o,
  output logic exc_zero_o,
  output logic postfilt_o,
  output logic wb_test_o,
  output logic [3:0] enc_mode_o,
  output logic [3:0] dec_mode_o
);
  // ************************************************************
  // parameter check
  // ************************************************************
  // the frame counter needs at least two states to find a boundary
  if (FRAME_LEN < 2) begin : g_bad_frame_len
    $error("frame length too short");
  end
  typedef logic [7:0] blk_t [9];
  // all state but the port registers in one record, built below and registered once
  typedef struct packed {
    logic [8:0][7:0] mbx;
    logic [8:0][7:0] act;
    logic [8:0][7:0] p1;
    logic [8:0][7:0] p2;
    logic [8:0][7:0] stat;
    logic pend;
    logic [7:0] d2h;
    logic h2d_busy;
    logic d2h_busy;
    logic irq;
    logic [7:0] rdata;
    logic [31:0] cnt;
  } st_s;
  st_s q, d;
  logic tick;
  logic [7:0] a;

  // ************************************************************
  // reset image of the control block
  // ************************************************************
  function automatic logic [8:0][7:0] rst_blk();
    logic [8:0][7:0] b;
    b = '0;
    b[OFS_PROTO_IF] = RST_PROTO_IF;
    b[OFS_LOW_DELAY] = RST_LOW_DELAY;
    return b;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    a = bus.addr;
    tick = offline_i ? frame_tick_i : (q.cnt == 32'(FRAME_LEN - 1));
    d.cnt = (offline_i || tick) ? 32'h0000_0000 : q.cnt + 32'h0000_0001;
    // a ring in the same cycle re-arms pend below, so the set wins
    // limitation: a status request while pend is set replaces the block
    // apply at frame boundary
    if (tick) begin
      if (q.pend) begin
        d.act = q.mbx;
        d.pend = 1'b0;
      end
      d.p1 = q.act;
      d.p2 = q.p1;
      d.stat = q.p2;
    end
    // read data stands for one cycle only and is zero otherwise
    d.rdata = 8'h00;
    if (bus.rd) begin
      if (a < MBX_WORDS) d.rdata = q.mbx[a[3:0]];
      else if (a == ADDR_H2D_DOORBELL) d.rdata = {7'h00, q.h2d_busy};
      else if (a == ADDR_D2H_DOORBELL) d.rdata = q.d2h;
      else if (a == ADDR_BUSY) d.rdata = {6'h00, q.d2h_busy, q.h2d_busy};
    end
    if (bus.wr) begin
      if (a < MBX_WORDS) d.mbx[a[3:0]] = bus.wdata;
      else if (a == ADDR_D2H_DOORBELL) begin
        d.d2h_busy = 1'b0;
        d.irq = 1'b0;
      end else if (a == ADDR_H2D_DOORBELL) begin
        case (bus.wdata)
          CODE_CTRL_NEW: begin
            d.pend = 1'b1;
            if (bus.wdata == CODE_CTRL_NEW &&
                q.mbx[OFS_MODE] == 8'h00)
              d.act[OFS_MODE] = 8'h00;
            d.h2d_busy = 1'b0;
            d.d2h = CODE_CTRL_ACK;
            d.d2h_busy = 1'b1;
            d.irq = 1'b1;
          end
          CODE_STAT_REQ: begin
            d.mbx = q.stat;
            d.h2d_busy = 1'b0;
            d.d2h = CODE_STAT_RDY;
            d.d2h_busy = 1'b1;
            d.irq = 1'b1;
          end
          CODE_STAT_ACK: d.h2d_busy = 1'b0;
          // unknown codes only mark the host doorbell busy
          default: d.h2d_busy = 1'b1;
        endcase
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mbx <= rst_blk();
      q.act <= rst_blk();
      q.p1 <= rst_blk();
      q.p2 <= rst_blk();
      q.stat <= rst_blk();
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // port registers, and outputs from the active block
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus.rdata <= 8'h00;
      bus.irq <= 1'b0;
      // codec outputs show the reset block, so they agree with the active copy
      inband_o <= RST_PROTO_IF[PROTO_SEL_BIT];
      if_route_o <= RST_PROTO_IF[IF_SEL_LSB +: 2];
      frame_len_o <= RST_PROTO_IF[FRAME_LEN_BIT];
      ufmt_o <= RST_LOW_DELAY[UFMT_LSB +: 2];
      exc_zero_o <= RST_LOW_DELAY[EXC_ZERO_BIT];
      postfilt_o <= RST_LOW_DELAY[POSTFILT_BIT];
      wb_test_o <= RST_OTHER[WB_TEST_BIT];
      enc_mode_o <= RST_OTHER[ENC_MODE_LSB +: 4];
      dec_mode_o <= RST_OTHER[3:0];
    end else begin
      // codec outputs follow d.act, so they move on the edge the block does
      bus.rdata <= d.rdata;
      bus.irq <= d.irq;
      inband_o <= d.act[OFS_PROTO_IF][PROTO_SEL_BIT];
      if_route_o <= d.act[OFS_PROTO_IF][IF_SEL_LSB +: 2];
      frame_len_o <= d.act[OFS_PROTO_IF][FRAME_LEN_BIT];
      ufmt_o <= d.act[OFS_LOW_DELAY][UFMT_LSB +: 2];
      exc_zero_o <= d.act[OFS_LOW_DELAY][EXC_ZERO_BIT];
      postfilt_o <= d.act[OFS_LOW_DELAY][POSTFILT_BIT];
      wb_test_o <= d.act[OFS_WIDEBAND][WB_TEST_BIT];
      enc_mode_o <= d.act[OFS_MODE][ENC_MODE_LSB +: 4];
      dec_mode_o <= d.act[OFS_MODE][3:0];
    end
  end
endmodule

// ===== rtl/codec_ctrl_host.sv
// codec_ctrl_host: host side sequencer for the control mailbox
// assumes: device answers reads next cycle and raises irq on acks
module codec_ctrl_host
  import mailbox_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  mailbox_if.host bus,
  input wire logic cfg_start_i,
  input wire logic [71:0] cfg_block_i,
  input wire logic stat_start_i,
  output logic busy_o,
  output logic done_o,
  output logic [71:0] stat_block_o
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_LOAD = 6'b000010, S_RING = 6'b000100,
    S_WAIT = 6'b001000, S_READ = 6'b010000, S_ACK = 6'b100000
  } st_e;
  typedef struct packed {
    st_e st;
    logic stat;
    logic [3:0] idx;
    logic [71:0] blk;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rd_d;
    logic [3:0] rd_idx;
    logic done;
    logic busy;
  } hst_s;
  hst_s q, d;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.done = 1'b0;
    d.rd_d = q.rd;
    // the word read is the one addressed, idx has already moved on
    d.rd_idx = q.addr[3:0];
    if (q.rd_d)
      d.blk[8'(q.rd_idx) * 8 +: 8] = bus.rdata;
    case (q.st)
      S_IDLE: begin
        d.idx = 4'h0;
        if (cfg_start_i) begin
          d.blk = cfg_block_i;
          d.stat = 1'b0;
          d.st = S_LOAD;
        end else if (stat_start_i) begin
          d.stat = 1'b1;
          d.st = S_RING;
        end
      end
      S_LOAD: begin
        d.wr = 1'b1;
        d.addr = 8'(q.idx);
        d.wdata = q.blk[8'(q.idx) * 8 +: 8];
        d.idx = q.idx + 4'h1;
        if (q.idx == 4'(MBX_WORDS - 8'h01)) d.st = S_RING;
      end
      S_RING: begin
        d.wr = 1'b1;
        d.addr = ADDR_H2D_DOORBELL;
        d.wdata = q.stat ? CODE_STAT_REQ : CODE_CTRL_NEW;
        d.idx = 4'h0;
        d.st = S_WAIT;
      end
      // busy clear is optional, irq is enough
      S_WAIT: begin
        if (bus.irq) begin
          d.wr = 1'b1;
          d.addr = ADDR_D2H_DOORBELL;
          d.wdata = 8'h00;
          if (q.stat) d.st = S_READ;
          else begin
            d.done = 1'b1;
            d.st = S_IDLE;
          end
        end
      end
      S_READ: begin
        d.rd = 1'b1;
        d.addr = 8'(q.idx);
        d.idx = q.idx + 4'h1;
        if (q.idx == 4'(MBX_WORDS - 8'h01)) d.st = S_ACK;
      end
      S_ACK: begin
        if (!q.rd_d && !q.rd) begin
          d.wr = 1'b1;
          d.addr = ADDR_H2D_DOORBELL;
          d.wdata = CODE_STAT_ACK;
          d.done = 1'b1;
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
    d.busy = (d.st != S_IDLE);
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= S_IDLE;
    end else begin
      q <= d;
    end
  end

  // ports straight from the state record
  assign bus.addr = q.addr;
  assign bus.wdata = q.wdata;
  assign bus.wr = q.wr;
  assign bus.rd = q.rd;
  assign busy_o = q.busy;
  assign done_o = q.done;
  assign stat_block_o = q.blk;
endmodule

// ===== bench/mailbox_properties.sv
// mailbox_properties: doorbell and read timing on the host port
// assumes: sees the signals of the interface joining the two ends
module mailbox_checker
  import mailbox_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq
);
  // ****************
  // doorbell, read data and strobe timing
  // ****************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic ring, clr;
  // decoded doorbell writes
  assign ring = wr && addr == ADDR_H2D_DOORBELL;
  assign clr = wr && addr == ADDR_D2H_DOORBELL;
  a_cfg_ack: assert property (
    ring && wdata == CODE_CTRL_NEW |=> irq)
    else $error("no irq after config ring");
  a_stat_ack: assert property (
    ring && wdata == CODE_STAT_REQ |=> irq)
    else $error("no irq after status ring");
  a_irq_holds: assert property (
    irq && !clr |=> irq)
    else $error("irq dropped without clear");
  a_irq_clears: assert property (
    clr |=> !irq)
    else $error("irq stuck after clear");
  a_no_spurious: assert property (
    !irq && !(ring && (wdata == CODE_CTRL_NEW || wdata == CODE_STAT_REQ))
    |=> !irq)
    else $error("irq raised without request");
  a_rdata_idle: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  a_strobe_excl: assert property (
    !(wr && rd))
    else $error("both strobes at once");
  a_clear_after: assert property (
    $rose(irq) |-> ##[1:50] clr)
    else $error("host never cleared irq");
endmodule

// ===== bench/testbench.sv
// testbench: host and device ends joined, random control blocks
// assumes: frame length cut to 20 cycles, offline ticks from bench
module testbench
  import mailbox_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FL = 20;
  logic ref_clk_i = 0, rst_i = 1, cfg_start_i = 0, stat_start_i = 0;
  logic offline_i = 1, frame_tick_i = 0, busy_o, done_o, inband_o;
  logic frame_len_o, exc_zero_o, postfilt_o, wb_test_o;
  logic [1:0] if_route_o, ufmt_o;
  logic [3:0] enc_mode_o, dec_mode_o;
  logic [71:0] cfg_block_i = '0, stat_block_o, prev, blk, nb;
  logic [16:0] outs;
  logic [31:0] seed = 32'haf73;
  int bad_count = 0, total_checks = 0, cycles = 0;
  mailbox_if mbx();
  codec_ctrl_device #(.FRAME_LEN(FL)) i_codec_ctrl_device (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(mbx),
    .offline_i(offline_i), .frame_tick_i(frame_tick_i),
    .inband_o(inband_o), .if_route_o(if_route_o),
    .frame_len_o(frame_len_o), .ufmt_o(ufmt_o), .exc_zero_o(exc_zero_o),
    .postfilt_o(postfilt_o), .wb_test_o(wb_test_o),
    .enc_mode_o(enc_mode_o), .dec_mode_o(dec_mode_o));
  codec_ctrl_host i_codec_ctrl_host (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .bus(mbx), .cfg_start_i(cfg_start_i),
    .cfg_block_i(cfg_block_i), .stat_start_i(stat_start_i),
    .busy_o(busy_o), .done_o(done_o), .stat_block_o(stat_block_o));
  mailbox_checker i_mailbox_checker (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .addr(mbx.addr), .wdata(mbx.wdata), .wr(mbx.wr),
    .rd(mbx.rd), .rdata(mbx.rdata), .irq(mbx.irq));
  assign outs = {inband_o, if_route_o, frame_len_o, ufmt_o, exc_zero_o,
    postfilt_o, wb_test_o, enc_mode_o, dec_mode_o};
  // ****************
  // helpers
  // ****************
  always #5 ref_clk_i = ~ref_clk_i;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // outputs expected from an active block, same order as outs
  function automatic logic [16:0] exp_out(input logic [71:0] b);
    return {b[7:4], b[12:11], b[10], b[8], b[31], b[39:32]};
  endfunction
  function automatic logic [71:0] mk(input logic [1:0] isel,
    input logic [1:0] udf, input logic [7:0] mode);
    logic [31:0] r;
    r = xs();
    return {r, mode, r[23], 7'h00, 8'h00, 3'h0, udf, r[2], 1'b1, r[1],
      r[0], isel, 1'b0, 4'h1};
  endfunction
  task automatic chk_out(input logic [16:0] e);
    total_checks++;
    if (outs !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, outs, e);
    end
  endtask
  task automatic chk_blk(input logic [71:0] e);
    total_checks++;
    if (stat_block_o !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, stat_block_o, e);
    end
  endtask
  task automatic chk_busy(input logic e);
    total_checks++;
    if (busy_o !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy_o, e);
    end
  endtask
  // done is a one-cycle pulse, so look once per cycle after the edge
  task automatic wait_done();
    do begin
      @(posedge ref_clk_i);
      #1;
    end while (done_o !== 1'b1);
  endtask
  task automatic send(input logic [71:0] b);
    @(posedge ref_clk_i);
    cfg_start_i <= 1'b1;
    cfg_block_i <= b;
    @(posedge ref_clk_i);
    cfg_start_i <= 1'b0;
    #1;
    chk_busy(1'b1);
    wait_done();
    chk_busy(1'b0);
  endtask
  task automatic stat(input logic [71:0] e);
    @(posedge ref_clk_i);
    stat_start_i <= 1'b1;
    @(posedge ref_clk_i);
    stat_start_i <= 1'b0;
    wait_done();
    chk_blk(e);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      frame_tick_i <= 1'b1;
      @(posedge ref_clk_i);
      frame_tick_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
    end
    #1;
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    prev = {{7{RST_OTHER}}, RST_LOW_DELAY, RST_PROTO_IF};
    chk_out(exp_out(prev));
    stat(prev);
    // routing codes 0 to 2, format codes 1 to 3, three non-neutral mode codes
    for (int i = 0; i < 3; i++) begin
      blk = mk(i[1:0], i[1:0] + 2'd1, {4'(i + 1), 4'(5 - i)});
      send(blk);
      tick(1);
      chk_out(exp_out(blk));
      tick(2);
      stat(prev);
      tick(1);
      stat(blk);
      nb = {blk[71:40], 8'h00, blk[31:0]};
      send(nb);
      chk_out(exp_out(nb));
      tick(4);
      prev = nb;
    end
    // internal frame counter instead of bench ticks
    @(posedge ref_clk_i);
    offline_i <= 1'b0;
    blk = mk(2'b01, 2'b11, 8'h24);
    send(blk);
    repeat (6 * FL) @(posedge ref_clk_i);
    #1;
    chk_out(exp_out(blk));
    stat(blk);
    end_of_test();
  end
endmodule
